/* dv/general_purpose_port_pins_tb.sv */
// Testbench for the port block: register writes and reads, pin checks.
// Assumes the board model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "port_block_defs.vh"
module general_purpose_port_pins_tb;
   logic clock_i, rst_i, wr_i, rd_i, rt_trigger_low_i, rt_trigger_high_i;
   logic [4:0] addr_i;
   logic [7:0] wdata_i, rdata_o, input_only_port_pins_i, input_only_port_pull_o;
   logic [7:0] port_zero_pins_i, port_zero_pins_o, port_zero_pins_oe_o, port_zero_pull_o;
   logic [7:0] port_one_pins_i, port_one_pins_o, port_one_pins_oe_o, port_one_pull_o;
   logic [7:0] port_three_pins_i, port_three_pins_o, port_three_pins_oe_o, port_three_pull_o;
   logic [7:0] port_six_pins_i, port_six_pins_o, port_six_pins_oe_o, port_six_pull_o;
   logic [7:0] port_seven_pins_i, port_seven_pins_o, port_seven_pins_oe_o;
   logic [47:0] ext, ext_en;
   int bad_count = 0;
   int checks = 0;
   general_purpose_port_pins dut (.*);
   // ==========
   // Board on all pins; port two is never driven by the chip
   wire [47:0] level;
   pin_board board (.clock_i(clock_i),
      .drv_i({port_seven_pins_o, port_six_pins_o, port_three_pins_o, 8'h00, port_one_pins_o,
         port_zero_pins_o}),
      .oe_i({port_seven_pins_oe_o, port_six_pins_oe_o, port_three_pins_oe_o, 8'h00,
         port_one_pins_oe_o, port_zero_pins_oe_o}),
      .pull_i({8'h00, port_six_pull_o, port_three_pull_o, input_only_port_pull_o,
         port_one_pull_o, port_zero_pull_o}),
      .ext_i(ext), .ext_en_i(ext_en), .level_o(level));
   // Split the board levels back onto the pin inputs of each port
   assign {port_seven_pins_i, port_six_pins_i, port_three_pins_i, input_only_port_pins_i,
      port_one_pins_i, port_zero_pins_i} = level;
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   task automatic chk(input string n, input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input string n, input logic [4:0] a, input logic [7:0] e);
      @(posedge clock_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      chk(n, rdata_o, e);
   endtask
   // Pins follow a register change one edge after the register itself
   task automatic settle;
      repeat (2) @(posedge clock_i);
      #1;
   endtask
   task automatic pulse(input logic hi);
      @(posedge clock_i);
      rt_trigger_low_i <= !hi;
      rt_trigger_high_i <= hi;
      @(posedge clock_i);
      rt_trigger_low_i <= 1'b0;
      rt_trigger_high_i <= 1'b0;
      settle();
   endtask
   task automatic report_and_stop;
      if (bad_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      rst_i = 1'b1;
      {wr_i, rd_i, rt_trigger_low_i, rt_trigger_high_i} = 4'h0;
      addr_i = 5'h00;
      wdata_i = 8'h00;
      ext = 48'h0;
      ext_en = 48'h0;
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      settle();
      chk("oe", {port_seven_pins_oe_o, port_six_pins_oe_o, port_three_pins_oe_o,
         port_one_pins_oe_o, port_zero_pins_oe_o}, 40'h000F000000);
      chk("pull", {port_six_pull_o, port_three_pull_o, input_only_port_pull_o, port_one_pull_o,
         port_zero_pull_o}, 40'h0);
      rd("dir", `REG_P0_DIR, 8'hFF);
      // Pull-ups on, mixed directions on ports one, three and seven
      wr(`REG_PULLUP, 8'h1F);
      wr(`REG_P1_DIR, 8'h0F);
      wr(`REG_P3_DIR, 8'h55);
      wr(`REG_P7_DIR, 8'h3C);
      wr(`REG_P6_DIR, 8'h00);
      settle();
      chk("pull", {port_three_pull_o, input_only_port_pull_o, port_one_pull_o,
         port_zero_pull_o}, 32'h55FC0FFF);
      chk("p6 pull", port_six_pull_o & 8'hCF, 8'h00);
      chk("oe", {port_seven_pins_oe_o, port_six_pins_oe_o & 8'hCF, port_three_pins_oe_o,
         port_one_pins_oe_o}, 32'hC3CFAAF0);
      wr(`REG_P1_DATA, 8'hA5);
      settle();
      chk("p1 pins", port_one_pins_o & port_one_pins_oe_o, 8'hA0);
      rd("p1 data", `REG_P1_DATA, 8'hAF);
      // Only pins in output mode may show the written latch
      wr(`REG_P3_DATA, 8'hFF);
      wr(`REG_P6_DATA, 8'hFF);
      wr(`REG_P7_DATA, 8'hFF);
      settle();
      chk("p367 pins", {port_seven_pins_o, port_six_pins_o, port_three_pins_o}, 24'hC3CFAA);
      @(posedge clock_i);
      ext[23:16] <= 8'hC3;
      ext_en[23:16] <= 8'hFF;
      wr(5'h1F, 8'h00);
      settle();
      rd("p2 data", `REG_P2_DATA, 8'hC3);
      rd("pullup", `REG_PULLUP, 8'h1F);
      wr(`REG_PULLUP, 8'h00);
      settle();
      chk("pull off", {input_only_port_pull_o, port_zero_pull_o}, 16'h0);
      // Real-time nibbles: low enabled, high by software first
      wr(`REG_P0_DIR, 8'h00);
      wr(`REG_RT_CTRL, 8'h01);
      wr(`REG_RT_BUF, 8'hA5);
      pulse(1'b0);
      chk("rt low", port_zero_pins_o, 8'h05);
      wr(`REG_P0_DATA, 8'h3C);
      settle();
      chk("sw p0", port_zero_pins_o, 8'h35);
      pulse(1'b1);
      chk("rt high off", port_zero_pins_o, 8'h35);
      wr(`REG_RT_CTRL, 8'h03);
      wr(`REG_RT_TRIG, 8'h02);
      settle();
      chk("rt high", port_zero_pins_o, 8'hA5);
      report_and_stop();
   end
endmodule // general_purpose_port_pins_tb
`default_nettype wire

/* dv/pin_board.sv */
// Board model: the outside world on all port pins, concatenated by the bench.
// Assumes a released pin with no pull-up and no board driver floats.
`timescale 1ns/100ps
`default_nettype none
module pin_board #(
   parameter W = 48
) (
   input wire logic clock_i,
   input wire logic [W-1:0] drv_i,
   input wire logic [W-1:0] oe_i,
   input wire logic [W-1:0] pull_i,
   input wire logic [W-1:0] ext_i,
   input wire logic [W-1:0] ext_en_i,
   output logic [W-1:0] level_o
);
   logic [W-1:0] drift;
   // Floating lines toggle so a stale level never passes for a real one
   initial drift = '0;
   always @(posedge clock_i) begin
      drift <= ~drift;
   end
   // Chip driver wins, then board driver, then pull-up, else float
   assign level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i) |
      (~oe_i & ~ext_en_i & (pull_i | drift));
endmodule // pin_board
`default_nettype wire

/* dv/port_block_sva.sv */
// Checker for the port block: pull gating, fixed pins, reset state, direction lag.
// Assumes it is bound to general_purpose_port_pins and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "port_block_defs.vh"
module port_block_sva (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [4:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic [7:0] port_zero_pins_oe_o,
   input wire logic [7:0] port_zero_pull_o,
   input wire logic [7:0] port_one_pins_oe_o,
   input wire logic [7:0] port_one_pull_o,
   input wire logic [7:0] input_only_port_pull_o,
   input wire logic [7:0] port_three_pins_oe_o,
   input wire logic [7:0] port_three_pull_o,
   input wire logic [7:0] port_six_pins_oe_o,
   input wire logic [7:0] port_six_pull_o,
   input wire logic [7:0] port_seven_pins_oe_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // ==========
   // Direction writes reach the pin enables two edges later
   sequence s_p1_dir;
      wr_i && addr_i == `REG_P1_DIR;
   endsequence
   sequence s_p7_dir;
      wr_i && addr_i == `REG_P7_DIR;
   endsequence
   a_pull_p0_gate: assert property ((port_zero_pull_o & port_zero_pins_oe_o) == 8'h00)
      else $error("pull-up on a port zero output pin");
   a_pull_p13_gate: assert property (((port_one_pull_o & port_one_pins_oe_o) |
      (port_three_pull_o & port_three_pins_oe_o)) == 8'h00)
      else $error("pull-up on a port one or three output pin");
   a_p2_low_bare: assert property (input_only_port_pull_o[1:0] == 2'h0)
      else $error("pull-up on a low input-only pin");
   a_p2_pull_batch: assert property (input_only_port_pull_o[7:2] inside {6'h00, 6'h3F})
      else $error("input-only pull-ups not switched as a group");
   a_p6_out_fixed: assert property (!$past(rst_i) |->
      port_six_pins_oe_o[3:0] == 4'hF && port_six_pull_o[3:0] == 4'h0)
      else $error("port six output-only pins not driving");
   a_reset_input_mode: assert property ($past(rst_i) |-> (port_zero_pins_oe_o |
      port_one_pins_oe_o | port_three_pins_oe_o | port_seven_pins_oe_o | port_zero_pull_o) == 8'h00)
      else $error("pins not inputs without pull after reset");
   a_dir_p1_lag: assert property (s_p1_dir |-> ##2 port_one_pins_oe_o == ~$past(wdata_i, 2))
      else $error("port one enables do not follow direction write");
   a_dir_p7_lag: assert property (s_p7_dir |-> ##2 port_seven_pins_oe_o == ~$past(wdata_i, 2))
      else $error("port seven enables do not follow direction write");
endmodule // port_block_sva
bind general_purpose_port_pins port_block_sva u_sva (.*);
`default_nettype wire

/* include/port_block_defs.vh */
// Constants for the general-purpose port block: register indices, widths, reset values.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef PORT_BLOCK_DEFS_VH
`define PORT_BLOCK_DEFS_VH

// ==========================================================
// Register indices on the plain register port
`define REG_P0_DATA 5'h00
`define REG_P0_DIR 5'h01
`define REG_P1_DATA 5'h02
`define REG_P1_DIR 5'h03
`define REG_P2_DATA 5'h04
`define REG_P3_DATA 5'h05
`define REG_P3_DIR 5'h06
`define REG_P6_DATA 5'h07
`define REG_P6_DIR 5'h08
`define REG_P7_DATA 5'h09
`define REG_P7_DIR 5'h0A
`define REG_PULLUP 5'h0B
`define REG_RT_CTRL 5'h0C
`define REG_RT_BUF 5'h0D
`define REG_RT_TRIG 5'h0E

// ==========================================================
// Reset values: all directions input, pull-ups off
`define DIR_RESET 8'hFF
`define DATA_RESET 8'h00
`define PULLUP_RESET 8'h00
`define RT_CTRL_RESET 8'h00

// ==========================================================
// Field positions
`define PU_P0 0
`define PU_P1 1
`define PU_P2 2
`define PU_P3 3
`define PU_P6 4
`define RT_LOW_EN 0
`define RT_HIGH_EN 1
`define RT_TRIG_LOW 0
`define RT_TRIG_HIGH 1
`define P2_PU_MASK 8'hFC
`define P6_OUT_MASK 8'h0F
`define P6_BIDIR_MASK 8'hC0
`define NIBBLE_LOW 8'h0F
`define NIBBLE_HIGH 8'hF0
`define ZERO_BYTE 8'h00
`define ADDR_W 5

`endif

/* verilog/general_purpose_port_pins.v */
// General-purpose port block: ports 0,1,3,7 bidirectional, port 2 input-only,
// port 6 with four output-only and two bidirectional pins, port 0 real-time nibbles.
// Assumes a plain register port with read data one cycle after the read strobe,
// and an external trigger source for real-time output.
//
// Behaviour
// - Ports zero to six get software pull-ups on input pins; port seven none.
// - Ports 0,1,3,7 and port six upper pins set direction per bit.
// - Port zero lower and upper nibbles act as independent real-time outputs.
// - One pull-up bit per port covers only pins currently in input mode.
// - Port two is input-only; its pull-up covers only the six upper pins.
`timescale 1ns/100ps
`default_nettype none
`include "port_block_defs.vh"

module general_purpose_port_pins #(
   parameter WIDTH = 8
) (
   input wire clock_i,
   input wire rst_i,
   input wire [`ADDR_W-1:0] addr_i,
   input wire [WIDTH-1:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [WIDTH-1:0] rdata_o,
   input wire rt_trigger_low_i,
   input wire rt_trigger_high_i,
   input wire [WIDTH-1:0] port_zero_pins_i,
   output wire [WIDTH-1:0] port_zero_pins_o,
   output wire [WIDTH-1:0] port_zero_pins_oe_o,
   output wire [WIDTH-1:0] port_zero_pull_o,
   input wire [WIDTH-1:0] port_one_pins_i,
   output wire [WIDTH-1:0] port_one_pins_o,
   output wire [WIDTH-1:0] port_one_pins_oe_o,
   output wire [WIDTH-1:0] port_one_pull_o,
   input wire [WIDTH-1:0] input_only_port_pins_i,
   output reg [WIDTH-1:0] input_only_port_pull_o,
   input wire [WIDTH-1:0] port_three_pins_i,
   output wire [WIDTH-1:0] port_three_pins_o,
   output wire [WIDTH-1:0] port_three_pins_oe_o,
   output wire [WIDTH-1:0] port_three_pull_o,
   input wire [WIDTH-1:0] port_six_pins_i,
   output wire [WIDTH-1:0] port_six_pins_o,
   output wire [WIDTH-1:0] port_six_pins_oe_o,
   output wire [WIDTH-1:0] port_six_pull_o,
   input wire [WIDTH-1:0] port_seven_pins_i,
   output wire [WIDTH-1:0] port_seven_pins_o,
   output wire [WIDTH-1:0] port_seven_pins_oe_o
);

   // ==========================================================
   // Control registers
   reg [WIDTH-1:0] pullup_ctrl;
   reg [WIDTH-1:0] rt_ctrl;
   reg [WIDTH-1:0] rt_buf;
   reg [WIDTH-1:0] input_only_sample;

   wire [WIDTH-1:0] p0_in, p1_in, p3_in, p6_in, p7_in;
   wire [WIDTH-1:0] p0_latch, p1_latch, p3_latch, p6_latch, p7_latch;
   wire [WIDTH-1:0] p0_dir, p1_dir, p3_dir, p6_dir, p7_dir;
   wire [WIDTH-1:0] p0_mask;
   wire [WIDTH-1:0] p0_alt;

   // Write decode helper
   function wr_hit;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] target;
      input w;
      begin
         wr_hit = w & (a == target);
      end
   endfunction

   // Readback of a port: output latch on output pins, pin level on input pins
   function [WIDTH-1:0] port_view;
      input [WIDTH-1:0] latch;
      input [WIDTH-1:0] pins;
      input [WIDTH-1:0] dir;
      begin
         port_view = (latch & ~dir) | (pins & dir);
      end
   endfunction

   // Software writes: pull-up selection, real-time control and buffer
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pullup_ctrl <= `PULLUP_RESET;
         rt_ctrl <= `RT_CTRL_RESET;
         rt_buf <= `DATA_RESET;
      end else begin
         if (wr_hit(addr_i, `REG_PULLUP, wr_i))
            pullup_ctrl <= wdata_i;
         if (wr_hit(addr_i, `REG_RT_CTRL, wr_i))
            rt_ctrl <= wdata_i;
         if (wr_hit(addr_i, `REG_RT_BUF, wr_i))
            rt_buf <= wdata_i;
      end
   end

   // ==========================================================
   // Real-time nibbles: a nibble in real-time mode is loaded from the buffer
   // only on its own trigger, so the two groups never disturb each other
   wire rt_low_fire;
   wire rt_high_fire;
   assign rt_low_fire = rt_ctrl[`RT_LOW_EN] &
      (rt_trigger_low_i | (wr_hit(addr_i, `REG_RT_TRIG, wr_i) & wdata_i[`RT_TRIG_LOW]));
   assign rt_high_fire = rt_ctrl[`RT_HIGH_EN] &
      (rt_trigger_high_i | (wr_hit(addr_i, `REG_RT_TRIG, wr_i) & wdata_i[`RT_TRIG_HIGH]));
   // Mask bit 1 = software owns the bit; 0 = loaded from alt path
   assign p0_mask = ~(({WIDTH{rt_ctrl[`RT_LOW_EN]}} & `NIBBLE_LOW) |
      ({WIDTH{rt_ctrl[`RT_HIGH_EN]}} & `NIBBLE_HIGH));
   assign p0_alt = ((rt_low_fire ? rt_buf : p0_latch) & `NIBBLE_LOW) |
      ((rt_high_fire ? rt_buf : p0_latch) & `NIBBLE_HIGH);

   // ==========================================================
   // Ports with per-bit direction
   port_pin_cell #(.WIDTH(WIDTH)) u_port0 (
      .clock_i(clock_i), .rst_i(rst_i),
      .data_we_i(wr_hit(addr_i, `REG_P0_DATA, wr_i)),
      .dir_we_i(wr_hit(addr_i, `REG_P0_DIR, wr_i)),
      .wdata_i(wdata_i), .data_mask_i(p0_mask), .alt_data_i(p0_alt),
      .pullup_en_i(pullup_ctrl[`PU_P0]), .pin_i(port_zero_pins_i),
      .pin_o(port_zero_pins_o), .pin_oe_o(port_zero_pins_oe_o),
      .pull_o(port_zero_pull_o), .pin_in_o(p0_in), .latch_o(p0_latch), .dir_o(p0_dir));

   port_pin_cell #(.WIDTH(WIDTH)) u_port1 (
      .clock_i(clock_i), .rst_i(rst_i),
      .data_we_i(wr_hit(addr_i, `REG_P1_DATA, wr_i)),
      .dir_we_i(wr_hit(addr_i, `REG_P1_DIR, wr_i)),
      .wdata_i(wdata_i), .data_mask_i({WIDTH{1'b1}}), .alt_data_i(`ZERO_BYTE),
      .pullup_en_i(pullup_ctrl[`PU_P1]), .pin_i(port_one_pins_i),
      .pin_o(port_one_pins_o), .pin_oe_o(port_one_pins_oe_o),
      .pull_o(port_one_pull_o), .pin_in_o(p1_in), .latch_o(p1_latch), .dir_o(p1_dir));

   port_pin_cell #(.WIDTH(WIDTH)) u_port3 (
      .clock_i(clock_i), .rst_i(rst_i),
      .data_we_i(wr_hit(addr_i, `REG_P3_DATA, wr_i)),
      .dir_we_i(wr_hit(addr_i, `REG_P3_DIR, wr_i)),
      .wdata_i(wdata_i), .data_mask_i({WIDTH{1'b1}}), .alt_data_i(`ZERO_BYTE),
      .pullup_en_i(pullup_ctrl[`PU_P3]), .pin_i(port_three_pins_i),
      .pin_o(port_three_pins_o), .pin_oe_o(port_three_pins_oe_o),
      .pull_o(port_three_pull_o), .pin_in_o(p3_in), .latch_o(p3_latch), .dir_o(p3_dir));

   // Port six: low four output-only, pins 4 and 5 absent (held input, unused)
   port_pin_cell #(.WIDTH(WIDTH), .DIR_CAPABLE(`P6_BIDIR_MASK),
      .OUT_FIXED(`P6_OUT_MASK)) u_port6 (
      .clock_i(clock_i), .rst_i(rst_i),
      .data_we_i(wr_hit(addr_i, `REG_P6_DATA, wr_i)),
      .dir_we_i(wr_hit(addr_i, `REG_P6_DIR, wr_i)),
      .wdata_i(wdata_i), .data_mask_i({WIDTH{1'b1}}), .alt_data_i(`ZERO_BYTE),
      .pullup_en_i(pullup_ctrl[`PU_P6]), .pin_i(port_six_pins_i),
      .pin_o(port_six_pins_o), .pin_oe_o(port_six_pins_oe_o),
      .pull_o(port_six_pull_o), .pin_in_o(p6_in), .latch_o(p6_latch), .dir_o(p6_dir));

   // Port seven has no pull-up at all
   port_pin_cell #(.WIDTH(WIDTH)) u_port7 (
      .clock_i(clock_i), .rst_i(rst_i),
      .data_we_i(wr_hit(addr_i, `REG_P7_DATA, wr_i)),
      .dir_we_i(wr_hit(addr_i, `REG_P7_DIR, wr_i)),
      .wdata_i(wdata_i), .data_mask_i({WIDTH{1'b1}}), .alt_data_i(`ZERO_BYTE),
      .pullup_en_i(1'b0), .pin_i(port_seven_pins_i),
      .pin_o(port_seven_pins_o), .pin_oe_o(port_seven_pins_oe_o),
      .pull_o(), .pin_in_o(p7_in), .latch_o(p7_latch), .dir_o(p7_dir));

   // ==========================================================
   // Input-only port: sampled pins, pull-up on six upper bits only
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         input_only_sample <= `ZERO_BYTE;
         input_only_port_pull_o <= `ZERO_BYTE;
      end else begin
         input_only_sample <= input_only_port_pins_i;
         input_only_port_pull_o <= {WIDTH{pullup_ctrl[`PU_P2]}} & `P2_PU_MASK;
      end
   end

   // ==========================================================
   // Read mux; unmapped addresses read zero
   reg [WIDTH-1:0] next_rdata;
   always @* begin
      next_rdata = `ZERO_BYTE;
      case (addr_i)
         `REG_P0_DATA: next_rdata = port_view(p0_latch, p0_in, p0_dir);
         `REG_P0_DIR: next_rdata = p0_dir;
         `REG_P1_DATA: next_rdata = port_view(p1_latch, p1_in, p1_dir);
         `REG_P1_DIR: next_rdata = p1_dir;
         `REG_P2_DATA: next_rdata = input_only_sample;
         `REG_P3_DATA: next_rdata = port_view(p3_latch, p3_in, p3_dir);
         `REG_P3_DIR: next_rdata = p3_dir;
         `REG_P6_DATA: next_rdata = (p6_latch & `P6_OUT_MASK) |
            (port_view(p6_latch, p6_in, p6_dir) & `P6_BIDIR_MASK);
         `REG_P6_DIR: next_rdata = p6_dir & `P6_BIDIR_MASK;
         `REG_P7_DATA: next_rdata = port_view(p7_latch, p7_in, p7_dir);
         `REG_P7_DIR: next_rdata = p7_dir;
         `REG_PULLUP: next_rdata = pullup_ctrl;
         `REG_RT_CTRL: next_rdata = rt_ctrl;
         `REG_RT_BUF: next_rdata = rt_buf;
         default: next_rdata = `ZERO_BYTE;
      endcase
   end

   // Read data held only in the cycle after the strobe
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i)
         rdata_o <= `ZERO_BYTE;
      else if (rd_i)
         rdata_o <= next_rdata;
      else
         rdata_o <= `ZERO_BYTE;
   end

endmodule // general_purpose_port_pins
`default_nettype wire

/* verilog/port_pin_cell.v */
// One 8-bit bidirectional port: output latch, direction latch, pin drivers, pull-up gate.
// Assumes synchronous pin inputs and writes decoded by the parent.
`timescale 1ns/100ps
`default_nettype none
`include "port_block_defs.vh"

module port_pin_cell #(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] DIR_CAPABLE = {WIDTH{1'b1}},
   parameter [WIDTH-1:0] OUT_FIXED = {WIDTH{1'b0}}
) (
   input wire clock_i,
   input wire rst_i,
   input wire data_we_i,
   input wire dir_we_i,
   input wire [WIDTH-1:0] wdata_i,
   input wire [WIDTH-1:0] data_mask_i,
   input wire [WIDTH-1:0] alt_data_i,
   input wire pullup_en_i,
   input wire [WIDTH-1:0] pin_i,
   output reg [WIDTH-1:0] pin_o,
   output reg [WIDTH-1:0] pin_oe_o,
   output reg [WIDTH-1:0] pull_o,
   output reg [WIDTH-1:0] pin_in_o,
   output reg [WIDTH-1:0] latch_o,
   output reg [WIDTH-1:0] dir_o
);

   // Effective direction: 1 means input; output-only bits are forced to 0
   wire [WIDTH-1:0] eff_dir;
   assign eff_dir = (dir_o & DIR_CAPABLE) | (~DIR_CAPABLE & ~OUT_FIXED);

   // ==========================================================
   // Latches; the mask lets the parent keep real-time nibbles away from software
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         latch_o <= {WIDTH{1'b0}};
         dir_o <= {WIDTH{1'b1}};
      end else begin
         if (data_we_i)
            latch_o <= (wdata_i & data_mask_i) | (alt_data_i & ~data_mask_i);
         else
            latch_o <= (latch_o & data_mask_i) | (alt_data_i & ~data_mask_i);
         if (dir_we_i)
            dir_o <= wdata_i | ~DIR_CAPABLE;
      end
   end

   // ==========================================================
   // Pin drivers registered so every output comes from a flip-flop
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pin_o <= {WIDTH{1'b0}};
         pin_oe_o <= {WIDTH{1'b0}};
         pull_o <= {WIDTH{1'b0}};
         pin_in_o <= {WIDTH{1'b0}};
      end else begin
         pin_o <= latch_o & ~eff_dir;
         pin_oe_o <= ~eff_dir;
         pull_o <= {WIDTH{pullup_en_i}} & eff_dir;
         pin_in_o <= pin_i;
      end
   end

endmodule // port_pin_cell
`default_nettype wire
